// >>> srbwf_dev_model.sv
// behavioural model of the strobed ring-buffer device seen by the host
`timescale 1ns/10ps
`default_nettype none
module srbwf_dev_model
  import srbwf_pkg::*;
#(
  parameter int unsigned CAP = 8
) (
  input  wire logic              init_pulse_n_in,
  input  wire logic              push_strobe_n_in,
  input  wire logic              pop_strobe_n_in,
  input  wire logic [DATA_W-1:0] push_data_in,
  input  wire logic              first_in_chain_or_replay_n_in,
  input  wire logic              chain_in_n_in,
  output logic                   is_full_n_out,
  output logic                   is_empty_n_out,
  output logic                   chain_out_or_half_level_n_out,
  output logic      [DATA_W-1:0] pop_data_out,
  output logic                   bad_out
);
  logic [DATA_W-1:0] mem [CAP];
  logic [DATA_W-1:0] last;
  int unsigned       wp, rp, cnt;
  logic              wr_ok, rd_ok;
  initial begin
    last = 9'h000;
    wr_ok = 1'h0;
    rd_ok = 1'h0;
    bad_out = 1'h0;
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  always @(negedge init_pulse_n_in) begin
    wp = 0;
    rp = 0;
    cnt = 0;
  end
  // strobes must stay high as reset or replay rises
  always @(posedge init_pulse_n_in or posedge first_in_chain_or_replay_n_in)
    if (!push_strobe_n_in || !pop_strobe_n_in) bad_out = 1'h1;
  always @(negedge push_strobe_n_in)
    wr_ok = init_pulse_n_in && cnt < CAP;
  always @(posedge push_strobe_n_in) if (wr_ok) begin
    mem[wp] = push_data_in;
    wp = (wp + 1) % CAP;
    cnt++;
    wr_ok = 1'h0;
  end
  always @(negedge pop_strobe_n_in) rd_ok = cnt != 0;
  always @(posedge pop_strobe_n_in) if (rd_ok) begin
    last = mem[rp];
    rp = (rp + 1) % CAP;
    cnt--;
    rd_ok = 1'h0;
  end
  // count restored from the write pointer: valid below CAP writes per reset
  always @(negedge first_in_chain_or_replay_n_in) begin
    if (chain_in_n_in == 1'h0 && init_pulse_n_in) begin
      rp = 0;
      cnt = wp;
    end
  end
  assign is_full_n_out = cnt != CAP;
  assign is_empty_n_out = cnt != 0;
  assign chain_out_or_half_level_n_out = !(cnt > CAP / 2);
  // released bus shows the inverse of the last word, never a stale match
  assign pop_data_out = (!pop_strobe_n_in && rd_ok) ? mem[rp] : ~last;
endmodule : srbwf_dev_model
`default_nettype wire

// >>> srbwf_host.sv
// host controller that drives a strobed ring-buffer device through its pins
`timescale 1ns/10ps
`default_nettype none
// Device rules this block is written to
// [R1] reset the device before any write
// [R2] strobes high around reset rise
// [R3] half flag reads high after reset
// [R4] write only while full flag high
// [R5] data stable through write strobe rise
// [R6] half flag falls past half capacity
// [R7] half flag rises after read at half
// [R8] full device ignores write strobe
// [R9] full flag releases after a read
// [R10] full when write trails read by one
// [R11] capacity selectable, full after capacity writes
// [R12] read only while empty flag high
// [R13] read data valid only strobe low
// [R14] empty when pointers are equal
// [R15] empty device ignores read strobe
// [R16] empty flag releases after a write
// [R17] chain input grounded selects single mode
// [R18] replay pulse rewinds read pointer only
// [R19] strobes high during replay pulse
// [R20] replay only in single mode
// [R21] chain output doubles as half flag
// [R22] nine-bit data both ways
// [R23] capacity is a build parameter
module srbwf_host
  import srbwf_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic              push_valid_in,
  output logic                   push_ready_out,
  input  wire logic [DATA_W-1:0] push_data_in,
  input  wire logic              pop_req_in,
  output logic                   pop_valid_out,
  output logic      [DATA_W-1:0] pop_data_out,
  input  wire logic              replay_req_in,
  input  wire logic              reset_req_in,
  output logic                   busy_out,
  output logic                   status_full_out,
  output logic                   status_empty_out,
  output logic                   status_half_out,
  output logic                   init_pulse_n_out,
  output logic                   push_strobe_n_out,
  output logic                   pop_strobe_n_out,
  output logic      [DATA_W-1:0] push_data_out,
  input  wire logic [DATA_W-1:0] pop_data_in,
  output logic                   first_in_chain_or_replay_n_out,
  output logic                   chain_in_n_out,
  input  wire logic              is_full_n_in,
  input  wire logic              is_empty_n_in,
  input  wire logic              chain_out_or_half_level_n_in
);
  srbwf_state_e      state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              pop_pend_ff, nxt_pop_pend;
  logic              rt_pend_ff, nxt_rt_pend;
  logic              rst_pend_ff, nxt_rst_pend;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic              rvalid_ff, nxt_rvalid;
  logic              init_n_ff, nxt_init_n;
  logic              wstb_n_ff, nxt_wstb_n;
  logic              rstb_n_ff, nxt_rstb_n;
  logic              rt_n_ff, nxt_rt_n;
  logic              busy_ff, nxt_busy;
  logic              full_ff, empty_ff, half_ff;
  logic              q_valid, q_ready;
  logic [DATA_W-1:0] q_data;
  logic              cnt_done;

  // back-pressure: a full device stalls draining, so the queue fills
  srbwf_queue #(
    .WIDTH (DATA_W),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .ce_in         (ce_in),
    .in_valid_in   (push_valid_in),
    .in_ready_out  (push_ready_out),
    .in_data_in    (push_data_in),
    .out_valid_out (q_valid),
    .out_ready_in  (q_ready),
    .out_data_out  (q_data)
  );

  always_comb begin
    cnt_done     = cnt_ff == CNT_ZERO;
    nxt_state    = state_ff;
    nxt_cnt      = cnt_done ? CNT_ZERO : CNT_W'(cnt_ff - CNT_ONE);
    nxt_pop_pend = pop_pend_ff | pop_req_in;
    nxt_rt_pend  = rt_pend_ff | replay_req_in;
    nxt_rst_pend = rst_pend_ff | reset_req_in;
    nxt_wdata    = wdata_ff;
    nxt_rdata    = rdata_ff;
    nxt_rvalid   = 1'b0;
    q_ready      = 1'b0;
    case (state_ff)
      SRBWF_IDLE: begin
        if (rst_pend_ff) begin
          nxt_state    = SRBWF_RST_LOW;
          nxt_cnt      = CNT_W'(RST_PULSE_CYC - CNT_ONE);
          nxt_rst_pend = reset_req_in;
        end else if (rt_pend_ff) begin
          // single mode is strapped, so replay is always legal here
          nxt_state   = SRBWF_RT_LOW; // [R18] [R20]
          nxt_cnt     = CNT_W'(RT_PULSE_CYC - CNT_ONE);
          nxt_rt_pend = replay_req_in;
        end else if (pop_pend_ff && is_empty_n_in) begin
          nxt_state    = SRBWF_RD_LOW; // [R12] [R15]
          nxt_cnt      = CNT_W'(STB_PULSE_CYC - CNT_ONE);
          nxt_pop_pend = pop_req_in;
        end else if (q_valid && is_full_n_in) begin
          nxt_state = SRBWF_WR_LOW; // [R4] [R8]
          nxt_cnt   = CNT_W'(STB_PULSE_CYC - CNT_ONE);
          nxt_wdata = q_data; // [R22]
          q_ready   = 1'b1;
        end
      end
      SRBWF_RST_LOW: begin
        if (cnt_done) begin
          nxt_state = SRBWF_RST_REC; // [R1]
          nxt_cnt   = CNT_W'(RST_REC_CYC - CNT_ONE);
        end
      end
      SRBWF_WR_LOW: begin
        if (cnt_done) begin
          nxt_state = SRBWF_WR_REC; // [R5]
          nxt_cnt   = CNT_W'(STB_REC_CYC - CNT_ONE);
        end
      end
      SRBWF_RD_LOW: begin
        if (cnt_done) begin
          // sample while the strobe is still low, data float after
          nxt_state  = SRBWF_RD_REC; // [R13]
          nxt_cnt    = CNT_W'(STB_REC_CYC - CNT_ONE);
          nxt_rdata  = pop_data_in;
          nxt_rvalid = 1'b1;
        end
      end
      SRBWF_RT_LOW: begin
        if (cnt_done) begin
          nxt_state = SRBWF_RT_REC;
          nxt_cnt   = CNT_W'(RT_REC_CYC - CNT_ONE);
        end
      end
      SRBWF_RST_REC, SRBWF_WR_REC, SRBWF_RD_REC, SRBWF_RT_REC: begin
        // recovery cycle also lets device flags settle before next look
        if (cnt_done) begin
          nxt_state = SRBWF_IDLE; // [R9] [R16]
        end
      end
      default: begin
        nxt_state = SRBWF_RST_LOW;
        nxt_cnt   = CNT_ZERO;
      end
    endcase
    nxt_init_n = nxt_state != SRBWF_RST_LOW; // [R1]
    nxt_wstb_n = nxt_state != SRBWF_WR_LOW; // [R2] [R19]
    nxt_rstb_n = nxt_state != SRBWF_RD_LOW; // [R2] [R19]
    nxt_rt_n   = nxt_state != SRBWF_RT_LOW; // [R17]
    nxt_busy   = nxt_state != SRBWF_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff    <= SRBWF_RST_LOW;
      cnt_ff      <= CNT_W'(RST_PULSE_CYC - CNT_ONE);
      pop_pend_ff <= 1'b0;
      rt_pend_ff  <= 1'b0;
      rst_pend_ff <= 1'b0;
      wdata_ff    <= '0;
      rdata_ff    <= '0;
      rvalid_ff   <= 1'b0;
      init_n_ff   <= 1'b0;
      wstb_n_ff   <= 1'b1;
      rstb_n_ff   <= 1'b1;
      rt_n_ff     <= 1'b1;
      busy_ff     <= 1'b1;
    end else if (ce_in) begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      pop_pend_ff <= nxt_pop_pend;
      rt_pend_ff  <= nxt_rt_pend;
      rst_pend_ff <= nxt_rst_pend;
      wdata_ff    <= nxt_wdata;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
      init_n_ff   <= nxt_init_n;
      wstb_n_ff   <= nxt_wstb_n;
      rstb_n_ff   <= nxt_rstb_n;
      rt_n_ff     <= nxt_rt_n;
      busy_ff     <= nxt_busy;
    end
  end

  // flag copies for the user; one cycle behind the device pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      full_ff  <= 1'b0;
      empty_ff <= 1'b1;
      half_ff  <= 1'b0;
    end else if (ce_in) begin
      full_ff  <= !is_full_n_in; // [R10] [R11]
      empty_ff <= !is_empty_n_in; // [R14]
      half_ff  <= !chain_out_or_half_level_n_in; // [R3] [R6] [R7] [R21]
    end
  end

  assign init_pulse_n_out               = init_n_ff;
  assign push_strobe_n_out              = wstb_n_ff;
  assign pop_strobe_n_out               = rstb_n_ff;
  assign push_data_out                  = wdata_ff;
  assign first_in_chain_or_replay_n_out = rt_n_ff;
  assign chain_in_n_out                 = STRAP_SINGLE_N; // [R17]
  assign pop_valid_out                  = rvalid_ff;
  assign pop_data_out                   = rdata_ff;
  assign busy_out                       = busy_ff;
  assign status_full_out                = full_ff;
  assign status_empty_out               = empty_ff;
  assign status_half_out                = half_ff;

  logic seen_reset_ff;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seen_reset_ff <= 1'b0;
    end else if (ce_in && !init_n_ff) begin
      seen_reset_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in || !ce_in);

  a_wr_after_reset: assert property ( // [R1]
    $fell(push_strobe_n_out) |-> seen_reset_ff)
    else $error("write strobe before device reset");
  a_rst_strobes_high: assert property ( // [R2]
    $rose(init_pulse_n_out) |-> push_strobe_n_out && pop_strobe_n_out
      && $past(push_strobe_n_out) && $past(pop_strobe_n_out))
    else $error("strobe low around reset release");
  a_rst_recovery: assert property ( // [R2]
    $rose(init_pulse_n_out) |=> push_strobe_n_out && pop_strobe_n_out)
    else $error("strobe fell inside reset recovery");
  a_wr_not_full: assert property ( // [R4]
    $fell(push_strobe_n_out) |-> $past(is_full_n_in))
    else $error("write started while device full");
  a_wr_data_hold: assert property ( // [R5]
    $rose(push_strobe_n_out) |-> $stable(push_data_out))
    else $error("write data moved at strobe rise");
  a_rd_not_empty: assert property ( // [R12]
    $fell(pop_strobe_n_out) |-> $past(is_empty_n_in))
    else $error("read started while device empty");
  a_rd_capture: assert property ( // [R13]
    pop_valid_out |-> $past(!pop_strobe_n_out) && pop_strobe_n_out
      && pop_data_out == $past(pop_data_in))
    else $error("read data not taken while strobe low");
  a_replay_quiet: assert property ( // [R19]
    !first_in_chain_or_replay_n_out |-> push_strobe_n_out
      && pop_strobe_n_out ##1 push_strobe_n_out && pop_strobe_n_out)
    else $error("strobe active around replay pulse");
  a_single_strap: assert property ( // [R17]
    !first_in_chain_or_replay_n_out |-> !chain_in_n_out)
    else $error("replay issued outside single mode");

  c_write: cover property ($fell(push_strobe_n_out));
  c_read: cover property (pop_valid_out);
  c_replay: cover property ($fell(first_in_chain_or_replay_n_out));
  c_queue_full: cover property (!push_ready_out && push_valid_in);
endmodule : srbwf_host
`default_nettype wire

// >>> srbwf_pkg.sv
// constants shared by the ring-buffer host controller and its write queue
package srbwf_pkg;
  localparam int unsigned DATA_W        = 9;
  localparam int unsigned QUEUE_DEPTH   = 4;
  localparam int unsigned DEV_CAPACITY  = 512;
  localparam int unsigned DEV_PTR_W     = $clog2(DEV_CAPACITY);
  localparam int unsigned DEV_HALF_MARK = DEV_CAPACITY / 2;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RST_PULSE_NS  = 20;
  localparam int unsigned RST_REC_NS    = 10;
  localparam int unsigned RT_PULSE_NS   = 20;
  localparam int unsigned RT_REC_NS     = 10;
  localparam int unsigned STB_PULSE_NS  = 20;
  localparam int unsigned STB_REC_NS    = 10;
  localparam int unsigned CNT_W         = 4;
  localparam logic [CNT_W-1:0] RST_PULSE_CYC = CNT_W'(
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RST_REC_CYC = CNT_W'(
    (RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RT_PULSE_CYC = CNT_W'(
    (RT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RT_REC_CYC = CNT_W'(
    (RT_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STB_PULSE_CYC = CNT_W'(
    (STB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STB_REC_CYC = CNT_W'(
    (STB_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam logic             STRAP_SINGLE_N = 1'b0;

  typedef enum logic [3:0] {
    SRBWF_IDLE    = 4'h0,
    SRBWF_RST_LOW = 4'h1,
    SRBWF_RST_REC = 4'h3,
    SRBWF_WR_LOW  = 4'h2,
    SRBWF_WR_REC  = 4'h6,
    SRBWF_RD_LOW  = 4'h7,
    SRBWF_RD_REC  = 4'h5,
    SRBWF_RT_LOW  = 4'h4,
    SRBWF_RT_REC  = 4'hc
  } srbwf_state_e;
endpackage : srbwf_pkg

// >>> srbwf_queue.sv
// small valid/ready queue that holds words waiting to be written out
`timescale 1ns/10ps
`default_nettype none
module srbwf_queue
  import srbwf_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [PW:0]      count_ff, nxt_count;
  logic             ready_ff, nxt_ready;
  logic             push, pop;

  always_comb begin
    push       = in_valid_in && ready_ff;
    pop        = out_ready_in && (count_ff != '0);
    nxt_wr_ptr = push ? PW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? PW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count  = count_ff;
    if (push && !pop) begin
      nxt_count = (PW+1)'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = (PW+1)'(count_ff - 1'b1);
    end
    nxt_ready  = nxt_count != DEPTH_C;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b1;
    end else if (ce_in) begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      ready_ff  <= nxt_ready;
    end
  end

  // storage carries no reset; only pointers, count and ready flag need a defined start
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk_in) begin
      if (ce_in && push && (wr_ptr_ff == PW'(i))) begin
        mem_ff[i] <= in_data_in;
      end
    end
  end

  assign in_ready_out  = ready_ff;
  assign out_valid_out = count_ff != '0;
  assign out_data_out  = mem_ff[rd_ptr_ff];
endmodule : srbwf_queue
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the ring-buffer host against the device model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import srbwf_pkg::*;
  localparam int unsigned CAP = 8;
  logic              clk_in, rst_n_in, push_valid_in, pop_req_in, bad, ce_in;
  logic              replay_req_in, reset_req_in, busy_out, push_ready_out;
  logic              pop_valid_out, st_full, st_empty, st_half, init_n;
  logic              wr_n, rd_n, rt_n, xi_n, ff_n, ef_n, hf_n;
  logic [DATA_W-1:0] push_data_in, pop_data_out, dev_d, dev_q;
  logic [DATA_W-1:0] exp_q[$], sent[$], keep[$];
  int                n_fail, check_count;
  initial clk_in = 1'h0;
  always #50 clk_in = ~clk_in;
  srbwf_host dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .push_valid_in(push_valid_in), .push_ready_out(push_ready_out),
    .push_data_in(push_data_in), .pop_req_in(pop_req_in),
    .pop_valid_out(pop_valid_out), .pop_data_out(pop_data_out),
    .replay_req_in(replay_req_in), .reset_req_in(reset_req_in),
    .busy_out(busy_out), .status_full_out(st_full),
    .status_empty_out(st_empty), .status_half_out(st_half),
    .init_pulse_n_out(init_n), .push_strobe_n_out(wr_n),
    .pop_strobe_n_out(rd_n), .push_data_out(dev_d), .pop_data_in(dev_q),
    .first_in_chain_or_replay_n_out(rt_n), .chain_in_n_out(xi_n),
    .is_full_n_in(ff_n), .is_empty_n_in(ef_n),
    .chain_out_or_half_level_n_in(hf_n));
  srbwf_dev_model #(.CAP(CAP)) dev_u (.init_pulse_n_in(init_n),
    .push_strobe_n_in(wr_n), .pop_strobe_n_in(rd_n), .push_data_in(dev_d),
    .first_in_chain_or_replay_n_in(rt_n), .chain_in_n_in(xi_n),
    .is_full_n_out(ff_n), .is_empty_n_out(ef_n),
    .chain_out_or_half_level_n_out(hf_n), .pop_data_out(dev_q),
    .bad_out(bad));
  task chk_flag(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_flag
  task chk_word(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // busy drops for one cycle between transfers, so wait for a quiet run
  task idle;
    int k;
    k = 0;
    for (int i = 0; i < 300 && k < 6; i++) begin
      @(negedge clk_in);
      k = (busy_out === 1'h0) ? k + 1 : 0;
    end
  endtask : idle
  task push(input logic [DATA_W-1:0] w);
    @(negedge clk_in);
    while (push_ready_out !== 1'h1) @(negedge clk_in);
    push_valid_in = 1'h1;
    push_data_in = w;
    sent.push_back(w);
    @(negedge clk_in);
    push_valid_in = 1'h0;
  endtask : push
  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'h1;
    @(negedge clk_in);
    s = 1'h0;
    idle();
  endtask : pulse
  task pop_one;
    exp_q.push_back(sent.pop_front());
    pulse(pop_req_in);
  endtask : pop_one
  always @(negedge clk_in) if (pop_valid_out === 1'h1)
    chk_word("pop_data", exp_q.size() ? exp_q.pop_front() : ~pop_data_out,
             pop_data_out);
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end
  initial begin
    {rst_n_in, push_valid_in, pop_req_in, replay_req_in, reset_req_in} = 5'h00;
    ce_in = 1'h1;
    push_data_in = 9'h000;
    n_fail = 0;
    check_count = 0;
    void'($urandom(32'h5938));
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'h1;
    idle();
    chk_flag("half", 1'h0, st_half);
    chk_flag("empty", 1'h1, st_empty);
    chk_flag("chain_in", 1'h0, xi_n);
    $display("test reset done");
    // one word beyond capacity has to wait in the host queue
    for (int i = 0; i <= CAP; i++) push(9'($urandom));
    idle();
    chk_flag("full", 1'h1, st_full);
    chk_flag("half", 1'h1, st_half);
    pop_one();
    chk_flag("full", 1'h1, st_full);
    $display("test fill done");
    repeat (CAP / 2) pop_one();
    chk_flag("half", 1'h0, st_half);
    repeat (CAP / 2 - 1) pop_one();
    chk_flag("empty", 1'h0, st_empty);
    pop_one();
    chk_flag("empty", 1'h1, st_empty);
    push(9'h1a5);
    idle();
    chk_flag("empty", 1'h0, st_empty);
    pulse(reset_req_in);
    chk_flag("empty", 1'h1, st_empty);
    sent = {};
    $display("test drain done");
    repeat (3) push(9'($urandom));
    idle();
    keep = sent;
    repeat (2) pop_one();
    pulse(replay_req_in);
    sent = keep;
    repeat (3) pop_one();
    chk_flag("empty", 1'h1, st_empty);
    chk_flag("violation", 1'h0, bad);
    $display("test replay done");
    // a frozen host must not take a word offered while frozen
    @(negedge clk_in);
    ce_in = 1'h0;
    push_valid_in = 1'h1;
    push_data_in = 9'($urandom);
    repeat (3) @(negedge clk_in);
    push_valid_in = 1'h0;
    @(negedge clk_in);
    ce_in = 1'h1;
    idle();
    chk_flag("empty", 1'h1, st_empty);
    chk_flag("pops_pending", 1'h1, exp_q.size() == 0);
    $display("test freeze done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
